// File: rtl/pcimr_pkg.sv
// pcimr_pkg: offsets, field layouts, reset values and encodings for the
// configuration header cache line, latency, header type and class code registers.
// assumes byte offsets into a 256-byte configuration space.
package pcimr_pkg;

  // configuration offsets (byte addresses)
  localparam logic [7:0] OFS_CLASS_PI   = 8'h09;
  localparam logic [7:0] OFS_CLASS_SUB  = 8'h0A;
  localparam logic [7:0] OFS_CLASS_BASE = 8'h0B;
  localparam logic [7:0] OFS_LINE_LEN   = 8'h0C;
  localparam logic [7:0] OFS_TENURE     = 8'h0D;
  localparam logic [7:0] OFS_KIND       = 8'h0E;
  localparam logic [7:0] OFS_LAYOUT_LO  = 8'h10;
  localparam logic [7:0] OFS_LAYOUT_HI  = 8'h3F;

  // boot-load offsets in nonvolatile memory
  localparam logic [7:0] NV_CLASS_PI    = 8'h49;
  localparam logic [7:0] NV_CLASS_SUB   = 8'h4A;
  localparam logic [7:0] NV_CLASS_BASE  = 8'h4B;
  localparam logic [7:0] NV_TENURE      = 8'h4D;
  localparam logic [7:0] NV_KIND        = 8'h4E;

  // reset values
  localparam logic [7:0] RST_LINE_LEN   = 8'h00;
  localparam logic [4:0] RST_TENURE_HI  = 5'h00;
  localparam logic [6:0] RST_LAYOUT     = 7'h00;
  localparam logic [7:0] RST_CLASS_BASE = 8'hFF;
  localparam logic [7:0] RST_CLASS_SUB  = 8'h00;
  localparam logic [7:0] RST_CLASS_PI   = 8'h00;

  // field layout
  localparam int TEN_RW_LSB  = 3;
  localparam int TEN_RW_MSB  = 7;
  localparam int KIND_MF_BIT = 7;
  localparam int BYTE_W      = 8;
  localparam logic [2:0] TEN_LOW_ZERO   = 3'h0;
  localparam logic       KIND_SINGLE_FN = 1'b0;

  // class encodings
  localparam logic [7:0] CLASS_LAST_DEFINED = 8'h0C;
  localparam logic [7:0] CLASS_SIMPLE_COMM  = 8'h07;
  localparam logic [7:0] SUB_SERIAL         = 8'h00;
  localparam logic [7:0] SUB_OTHER          = 8'h80;
  localparam logic [7:0] PI_NONE            = 8'h00;
  localparam logic [7:0] PI_SERIAL_MAX      = 8'h02;

  // master bus commands
  localparam logic [3:0] CMD_MEM_WRITE      = 4'h7;
  localparam logic [3:0] CMD_MEM_WRITE_INV  = 4'hF;

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_TENURE,
    MS_EXPIRED,
    MS_STOPPING
  } pcimr_mst_state_t;

endpackage

// File: rtl/pcimr_tenure_ctr.sv
// pcimr_tenure_ctr: down counter of guaranteed bus tenure clocks.
// assumes load and run come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pcimr_tenure_ctr
  import pcimr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       run,
  // state
  output logic      [7:0] count_q,
  output logic            zero_q
);

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= 8'h00;
    end else if (load) begin
      count_q <= load_val;
    end else if (run && count_q != 8'h00) begin
      count_q <= count_q - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      zero_q <= 1'b1;
    end else if (load) begin
      zero_q <= (load_val == 8'h00);
    end else if (run) begin
      zero_q <= (count_q <= 8'h01);
    end
  end

endmodule
`default_nettype wire

// File: rtl/pcimr_misc_regs.sv
// pcimr_misc_regs: cache line size, latency timer, header type and class
// code bytes of the configuration header, plus master tenure control.
// assumes config accesses and master engine signals on clk; gnt_n is a pin.
//
// Operation
// - cache line size byte reads zero; writes are ignored.
// - master never issues memory write and invalidate.
// - latency timer only acts while device is bus master.
// - nonzero latency value counts down per clock once frame driven.
// - before count reaches zero, grant removal does not stop transfers.
// - header bit 7 reports single function, always zero.
// - header bits 6:0 give layout of bytes 10h-3Fh, reset zero.
// - sub-class 80h with interface 00h means other function.
// - simple comm sub-class 00h uses interface 00h..02h for serial level.
// - base class resets to FFh; boot data may replace it.
`timescale 1ns/1ps
`default_nettype none
module pcimr_misc_regs
  import pcimr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // configuration access
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata_q,
  output logic             cfg_rvalid_q,
  // boot-load from nonvolatile memory
  input  wire logic        boot_wr,
  input  wire logic [7:0]  boot_addr,
  input  wire logic [7:0]  boot_data,
  // master engine
  input  wire logic        mst_frame_start,
  input  wire logic        mst_active,
  input  wire logic [3:0]  mst_cmd_req,
  output logic      [3:0]  mst_cmd_q,
  output logic             mst_stop_q,
  output logic             mst_tenure_left_q,
  // arbiter pin
  input  wire logic        gnt_n,
  // class code status
  output logic             class_defined_q,
  output logic             class_other_q,
  output logic             serial_level_valid_q,
  output logic      [1:0]  serial_level_q
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic       sel_class;
  logic       sel_misc;
  logic [7:0] lane_pi;
  logic [7:0] lane_ten;

  assign sel_class = (cfg_addr[7:2] == OFS_CLASS_PI[7:2]);
  assign sel_misc  = (cfg_addr[7:2] == OFS_LINE_LEN[7:2]);
  assign lane_pi   = cfg_wdata[8*OFS_CLASS_PI[1:0] +: BYTE_W];
  assign lane_ten  = cfg_wdata[8*OFS_TENURE[1:0] +: BYTE_W];

  ////////////////////////////////////////////////////////////////////////////
  // latency timer register

  logic [4:0] ten_hi_q;
  logic       ten_cfg_we;

  assign ten_cfg_we = cfg_wr && sel_misc && cfg_be[OFS_TENURE[1:0]];

  always_ff @(posedge clk) begin
    if (rst) begin
      ten_hi_q <= RST_TENURE_HI;
    end else if (ten_cfg_we) begin
      ten_hi_q <= lane_ten[TEN_RW_MSB:TEN_RW_LSB];
    end else if (boot_wr && boot_addr == NV_TENURE) begin
      ten_hi_q <= boot_data[TEN_RW_MSB:TEN_RW_LSB];
    end
  end

  logic [7:0] ten_val;

  assign ten_val = {ten_hi_q, TEN_LOW_ZERO};

  ////////////////////////////////////////////////////////////////////////////
  // header type register

  logic [6:0] layout_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      layout_q <= RST_LAYOUT;
    end else if (boot_wr && boot_addr == NV_KIND) begin
      layout_q <= boot_data[KIND_MF_BIT-1:0];
    end
  end

  logic [7:0] kind_val;

  // multifunction flag stays clear whatever boot data says
  assign kind_val = {KIND_SINGLE_FN, layout_q};

  ////////////////////////////////////////////////////////////////////////////
  // class code bytes, read only from configuration

  logic [7:0] cls_base_q;
  logic [7:0] cls_sub_q;
  logic [7:0] cls_pi_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cls_base_q <= RST_CLASS_BASE;
    end else if (boot_wr && boot_addr == NV_CLASS_BASE) begin
      cls_base_q <= boot_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cls_sub_q <= RST_CLASS_SUB;
    end else if (boot_wr && boot_addr == NV_CLASS_SUB) begin
      cls_sub_q <= boot_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cls_pi_q <= RST_CLASS_PI;
    end else if (boot_wr && boot_addr == NV_CLASS_PI) begin
      cls_pi_q <= boot_data;
    end
  end

  // class decode status
  logic defined_c;

  assign defined_c = (cls_base_q <= CLASS_LAST_DEFINED);

  always_ff @(posedge clk) begin
    if (rst) begin
      class_defined_q <= 1'b0;
      class_other_q   <= 1'b0;
    end else begin
      class_defined_q <= defined_c;
      class_other_q   <= defined_c && cls_sub_q == SUB_OTHER
                         && cls_pi_q == PI_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      serial_level_valid_q <= 1'b0;
      serial_level_q       <= 2'h0;
    end else begin
      serial_level_valid_q <= cls_base_q == CLASS_SIMPLE_COMM
                              && cls_sub_q == SUB_SERIAL
                              && cls_pi_q <= PI_SERIAL_MAX;
      serial_level_q       <= cls_pi_q[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration read path

  logic [31:0] rdata_c;

  always_comb begin
    rdata_c = 32'h0000_0000;
    if (sel_class) begin
      rdata_c[8*OFS_CLASS_PI[1:0]   +: BYTE_W] = cls_pi_q;
      rdata_c[8*OFS_CLASS_SUB[1:0]  +: BYTE_W] = cls_sub_q;
      rdata_c[8*OFS_CLASS_BASE[1:0] +: BYTE_W] = cls_base_q;
    end else if (sel_misc) begin
      rdata_c[8*OFS_LINE_LEN[1:0] +: BYTE_W] = RST_LINE_LEN;
      rdata_c[8*OFS_TENURE[1:0]   +: BYTE_W] = ten_val;
      rdata_c[8*OFS_KIND[1:0]     +: BYTE_W] = kind_val;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rdata_q  <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata_q <= rdata_c;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // grant pin synchroniser

  logic gnt_n_m_q;
  logic gnt_n_s_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      gnt_n_m_q <= 1'b1;
      gnt_n_s_q <= 1'b1;
    end else begin
      gnt_n_m_q <= gnt_n;
      gnt_n_s_q <= gnt_n_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master command filter

  always_ff @(posedge clk) begin
    if (rst) begin
      mst_cmd_q <= CMD_MEM_WRITE;
    end else if (mst_cmd_req == CMD_MEM_WRITE_INV) begin
      mst_cmd_q <= CMD_MEM_WRITE;
    end else begin
      mst_cmd_q <= mst_cmd_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master tenure control

  pcimr_mst_state_t ms_q;
  pcimr_mst_state_t ms_d;
  logic [7:0]       ten_count;
  logic             ten_zero;
  logic             ten_load;
  logic             ten_run;

  assign ten_load = mst_frame_start;
  assign ten_run  = (ms_q == MS_TENURE) && mst_active;

  pcimr_tenure_ctr u_tenure (
    .clk      (clk),
    .rst      (rst),
    .load     (ten_load),
    .load_val (ten_val),
    .run      (ten_run),
    .count_q  (ten_count),
    .zero_q   (ten_zero)
  );

  always_comb begin
    ms_d = ms_q;
    case (ms_q)
      MS_IDLE: begin
        if (mst_frame_start) begin
          ms_d = MS_TENURE;
        end
      end
      MS_TENURE: begin
        if (!mst_active) begin
          ms_d = MS_IDLE;
        end else if (ten_zero) begin
          ms_d = MS_EXPIRED;
        end
      end
      MS_EXPIRED: begin
        if (!mst_active) begin
          ms_d = MS_IDLE;
        end else if (gnt_n_s_q) begin
          ms_d = MS_STOPPING;
        end
      end
      MS_STOPPING: begin
        if (!mst_active) begin
          ms_d = MS_IDLE;
        end
      end
      default: begin
        ms_d = MS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ms_q <= MS_IDLE;
    end else begin
      ms_q <= ms_d;
    end
  end

  // stop request held until the engine drops its transaction
  always_ff @(posedge clk) begin
    if (rst) begin
      mst_stop_q <= 1'b0;
    end else begin
      mst_stop_q <= (ms_d == MS_STOPPING);
    end
  end

  // grant loss is ignored while tenure remains
  always_ff @(posedge clk) begin
    if (rst) begin
      mst_tenure_left_q <= 1'b0;
    end else begin
      mst_tenure_left_q <= (ms_d == MS_TENURE);
    end
  end

endmodule
`default_nettype wire

// File: testbench/pcimr_misc_regs_chk.sv
// pcimr_misc_regs_chk: port assertions for the misc config registers.
// assumes it is bound onto pcimr_misc_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pcimr_misc_regs_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // watched ports
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic        cfg_rvalid_q,
  input wire logic        mst_active,
  input wire logic [3:0]  mst_cmd_req,
  input wire logic [3:0]  mst_cmd_q,
  input wire logic        mst_stop_q,
  input wire logic        mst_tenure_left_q,
  input wire logic        gnt_n,
  input wire logic        class_defined_q,
  input wire logic        class_other_q,
  input wire logic        serial_level_valid_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_misc_rd;
    cfg_rd && cfg_addr[7:2] == 6'h03;
  endsequence
  sequence s_grant_gone;
    (mst_active && gnt_n && !mst_tenure_left_q)[*4];
  endsequence
  property p_rvalid;
    cfg_rd |=> cfg_rvalid_q;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_line_len;
    s_misc_rd |=> cfg_rdata_q[7:0] == 8'h00;
  endproperty
  a_line_len: assert property (p_line_len) else $error("line nonzero");
  property p_kind;
    s_misc_rd |=> !cfg_rdata_q[23] && cfg_rdata_q[31:24] == 8'h00;
  endproperty
  a_kind: assert property (p_kind) else $error("multifunction set");
  property p_ten_low;
    s_misc_rd |=> cfg_rdata_q[10:8] == 3'h0;
  endproperty
  a_ten_low: assert property (p_ten_low) else $error("low bits set");
  property p_no_mwi;
    mst_cmd_q != 4'hF;
  endproperty
  a_no_mwi: assert property (p_no_mwi) else $error("mwi issued");
  property p_cmd;
    mst_cmd_req != 4'hF |=> mst_cmd_q == $past(mst_cmd_req);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command altered");
  property p_keep;
    mst_tenure_left_q |-> !mst_stop_q;
  endproperty
  a_keep: assert property (p_keep) else $error("stop in tenure");
  property p_idle;
    !mst_active |=> !mst_stop_q;
  endproperty
  a_idle: assert property (p_idle) else $error("stop when idle");
  property p_stop;
    s_grant_gone |-> ##[0:3] mst_stop_q;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_class;
    class_other_q || serial_level_valid_q |-> class_defined_q;
  endproperty
  a_class: assert property (p_class) else $error("class flags");
endmodule
bind pcimr_misc_regs pcimr_misc_regs_chk pcimr_misc_regs_chk_inst (
  .clk(clk), .rst(rst), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
  .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
  .mst_active(mst_active), .mst_cmd_req(mst_cmd_req),
  .mst_cmd_q(mst_cmd_q), .mst_stop_q(mst_stop_q),
  .mst_tenure_left_q(mst_tenure_left_q), .gnt_n(gnt_n),
  .class_defined_q(class_defined_q), .class_other_q(class_other_q),
  .serial_level_valid_q(serial_level_valid_q));
`default_nettype wire

// File: testbench/pcimr_arb_model.sv
// pcimr_arb_model: arbiter granting on request, withdrawing after hold.
// assumes the bench raises req before the master starts its frame.
`timescale 1ns/1ps
`default_nettype none
module pcimr_arb_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // request and grant
  input  wire logic       req,
  input  wire logic [7:0] hold_clks,
  output logic            gnt_n
);
  logic [7:0] held_q;
  always @(posedge clk) begin
    if (rst || !req) begin
      held_q <= 8'h00;
      gnt_n  <= 1'b1;
    end else begin
      if (held_q != 8'hFF) begin
        held_q <= held_q + 8'h01;
      end
      gnt_n  <= (held_q >= hold_clks);
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb.sv
// tb: config reads and writes, boot loads and master tenure runs.
// assumes pcimr_misc_regs with the arbiter model on gnt_n.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pcimr_pkg::*;
  logic        clk = 0, rst = 1, cfg_rd = 0, cfg_wr = 0, boot_wr = 0;
  logic [7:0]  cfg_addr = 0, boot_addr = 0, boot_data = 0, hold = 8'hFF;
  logic [3:0]  cfg_be = 0, mst_cmd_req = 4'h7, mst_cmd_q;
  logic [31:0] cfg_wdata = 0, cfg_rdata_q;
  logic        mst_frame_start = 0, mst_active = 0, arb_req = 0, gnt_n;
  logic        cfg_rvalid_q, mst_stop_q, mst_tenure_left_q;
  logic        class_defined_q, class_other_q, serial_level_valid_q;
  logic [1:0]  serial_level_q;
  int          failures = 0, samples_checked = 0, cycles = 0, n;
  pcimr_misc_regs pcimr_misc_regs_inst (.clk(clk), .rst(rst),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rvalid_q(cfg_rvalid_q), .boot_wr(boot_wr),
    .boot_addr(boot_addr), .boot_data(boot_data),
    .mst_frame_start(mst_frame_start), .mst_active(mst_active),
    .mst_cmd_req(mst_cmd_req), .mst_cmd_q(mst_cmd_q),
    .mst_stop_q(mst_stop_q), .mst_tenure_left_q(mst_tenure_left_q),
    .gnt_n(gnt_n), .class_defined_q(class_defined_q),
    .class_other_q(class_other_q),
    .serial_level_valid_q(serial_level_valid_q),
    .serial_level_q(serial_level_q));
  pcimr_arb_model pcimr_arb_model_inst (.clk(clk), .rst(rst),
    .req(arb_req), .hold_clks(hold), .gnt_n(gnt_n));
  always #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    cfg_wr = 1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cfg_rd = 1;
    cfg_addr = a;
    @(negedge clk);
    chk(cfg_rvalid_q ? cfg_rdata_q : 32'hDEAD_BEEF, exp);
    cfg_rd = 0;
    @(negedge clk);
  endtask
  task automatic boot(input logic [7:0] a, input logic [7:0] d);
    boot_wr = 1;
    boot_addr = a;
    boot_data = d;
    @(negedge clk);
    boot_wr = 0;
    @(negedge clk);
  endtask
  task automatic cls(input logic [4:0] exp);
    @(negedge clk);
    chk({class_defined_q, class_other_q, serial_level_valid_q,
         serial_level_q}, exp);
  endtask
  task automatic tenure(input logic [7:0] tv, input int lo);
    wr(8'h0C, 4'b0010, {16'h0000, tv, 8'h00});
    hold = 8'h03;
    arb_req = 1;
    repeat (2) @(negedge clk);
    mst_frame_start = 1;
    mst_active = 1;
    @(negedge clk);
    mst_frame_start = 0;
    n = 0;
    while (mst_tenure_left_q === 1'b1 && n < 40) begin
      chk(32'(mst_stop_q), 0);
      @(negedge clk);
      n++;
    end
    chk(32'(n >= lo && n <= lo + 1), 1);
    repeat (5) @(negedge clk);
    chk(32'(mst_stop_q), 1);
    mst_active = 0;
    arb_req = 0;
    @(negedge clk);
    chk(32'(mst_stop_q), 0);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    rd(8'h0C, 32'h0000_0000);
    rd(8'h08, 32'hFF00_0000);
    wr(8'h0C, 4'b1111, 32'hFFFF_FFFF);
    wr(8'h08, 4'b1111, 32'h1234_5678);
    rd(8'h0C, 32'h0000_F800);
    rd(8'h08, 32'hFF00_0000);
    rd(8'h40, 32'h0000_0000);
    boot(8'h4E, 8'hFF);
    rd(8'h0C, 32'h007F_F800);
    boot(8'h4D, 8'h17);
    rd(8'h0C, 32'h007F_1000);
    boot(8'h4B, 8'h07);
    boot(8'h4A, 8'h00);
    boot(8'h49, 8'h02);
    cls(5'b10110);
    boot(8'h49, 8'h03);
    cls(5'b10011);
    boot(8'h4A, 8'h80);
    boot(8'h49, 8'h00);
    cls(5'b11000);
    boot(8'h4B, 8'h0D);
    cls(5'b00000);
    rd(8'h08, 32'h0D80_0000);
    mst_cmd_req = 4'hF;
    repeat (2) @(negedge clk);
    chk(32'(mst_cmd_q), 32'h7);
    mst_cmd_req = 4'h6;
    repeat (2) @(negedge clk);
    chk(32'(mst_cmd_q), 32'h6);
    tenure(8'h10, 16);
    tenure(8'h00, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
